// file: common/wetting_cfg_pkg.sv
// Operation
// - Codes 0-4 give off,1,2,5,10mA; 5-7 give 15mA; shared fields drive pairs.
// - Duration field bits 6-4 gives a cleaning pulse of 64us times code plus one.
// - Bits 3-0 pick 10mA or 15mA cleaning pulse current per group of six inputs.
// - Upper-input level register at 0x1e resets to zero.
// - Cleaning-pulse configuration register at 0x1f resets to zero.
// - Per-input cleaning-pulse enable register at 0x20 resets to zero.
// - Each enable bit set activates cleaning-pulse current on its input.
// - Select bit 0 means current source, 1 means sink; picks the auto-scale disable.
package wetting_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0]  UPPER_LEVEL_OFFSET  = 6'h1e;
  localparam logic [5:0]  PULSE_CONFIG_OFFSET = 6'h1f;
  localparam logic [5:0]  PULSE_ENABLE_OFFSET = 6'h20;
  localparam logic [23:0] REG_RESET_VALUE     = 24'h000000;
  localparam logic [23:0] UPPER_LEVEL_MASK    = 24'h7fffff;
  localparam logic [23:0] PULSE_CONFIG_MASK   = 24'h00007f;
  localparam logic [23:0] PULSE_ENABLE_MASK   = 24'hffffff;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SINK_AUTOSCALE_DISABLE_BIT   = 22;
  localparam int SOURCE_AUTOSCALE_DISABLE_BIT = 21;
  localparam int DURATION_LSB                 = 4;
  localparam int LEVEL_FIELD_WIDTH            = 3;
  localparam int COVERED_INPUTS               = 12;
  localparam int FIRST_COVERED_INPUT          = 12;
  localparam int GROUP_SIZE                   = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ        = 100;
  localparam int PULSE_UNIT_US       = 64;
  localparam int PULSE_UNIT_CYCLES   = PULSE_UNIT_US * CLK_FREQ_MHZ;

  // ****************************************
  // Normalised current levels
  // ****************************************
  typedef enum logic [2:0] {
    LEVEL_OFF  = 3'h0,
    LEVEL_1MA  = 3'h1,
    LEVEL_2MA  = 3'h2,
    LEVEL_5MA  = 3'h3,
    LEVEL_10MA = 3'h4,
    LEVEL_15MA = 3'h5
  } level_type;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'h0,
    PULSE_RUN  = 2'h1
  } pulse_state_type;

  // Codes above 4 collapse to 15mA
  function automatic level_type decode_level(input logic [2:0] code);
    decode_level = (code > 3'h4) ? LEVEL_15MA : level_type'(code);
  endfunction

  // Level field index serving covered input j
  function automatic int field_of(input int j);
    field_of = (j < 10) ? (j / 2) : (j - 5);
  endfunction

endpackage

// file: hdl/wetting_current_config_regs.sv
`timescale 1ns/100ps
module wetting_current_config_regs #(
  parameter int PULSE_UNIT_CYCLES = wetting_cfg_pkg::PULSE_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // Register access from serial frame decoder
  input  wire logic [5:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [23:0] i_reg_wdata,
  input  wire logic        i_reg_rd,
  output logic      [23:0] o_reg_rdata,
  // Switch state for inputs 12 to 23
  input  wire logic        i_continuous_mode,
  input  wire logic [11:0] i_switch_closed,
  input  wire logic [11:0] i_sink_select,
  // Cleaning pulse trigger
  input  wire logic        i_pulse_start,
  // Current control
  output logic      [35:0] o_wetting_level,
  output logic      [23:0] o_pulse_active,
  output logic      [23:0] o_pulse_level_15ma,
  output logic             o_pulse_busy
);

  // ****************************************
  // Register file
  // ****************************************
  logic [23:0] upper_q;
  logic [23:0] upper_d;
  logic [23:0] pcfg_q;
  logic [23:0] pcfg_d;
  logic [23:0] pen_q;
  logic [23:0] pen_d;
  logic [23:0] rdata_d;

  always_comb begin
    upper_d = upper_q;
    pcfg_d  = pcfg_q;
    pen_d   = pen_q;
    rdata_d = o_reg_rdata;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        wetting_cfg_pkg::UPPER_LEVEL_OFFSET:  upper_d = i_reg_wdata & wetting_cfg_pkg::UPPER_LEVEL_MASK;
        wetting_cfg_pkg::PULSE_CONFIG_OFFSET: pcfg_d  = i_reg_wdata & wetting_cfg_pkg::PULSE_CONFIG_MASK;
        wetting_cfg_pkg::PULSE_ENABLE_OFFSET: pen_d   = i_reg_wdata & wetting_cfg_pkg::PULSE_ENABLE_MASK;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        wetting_cfg_pkg::UPPER_LEVEL_OFFSET:  rdata_d = upper_q;
        wetting_cfg_pkg::PULSE_CONFIG_OFFSET: rdata_d = pcfg_q;
        wetting_cfg_pkg::PULSE_ENABLE_OFFSET: rdata_d = pen_q;
        default:                              rdata_d = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      upper_q     <= wetting_cfg_pkg::REG_RESET_VALUE;
      pcfg_q      <= wetting_cfg_pkg::REG_RESET_VALUE;
      pen_q       <= wetting_cfg_pkg::REG_RESET_VALUE;
      o_reg_rdata <= 24'h000000;
    end else begin
      upper_q     <= upper_d;
      pcfg_q      <= pcfg_d;
      pen_q       <= pen_d;
      o_reg_rdata <= rdata_d;
    end
  end

  // ****************************************
  // Wetting level with auto-scaling
  // ****************************************
  wire logic [35:0] level_d;

  for (genvar j = 0; j < wetting_cfg_pkg::COVERED_INPUTS; j++) begin : g_level
    localparam int FLSB = wetting_cfg_pkg::field_of(j) * wetting_cfg_pkg::LEVEL_FIELD_WIDTH;
    wetting_cfg_pkg::level_type raw;
    logic                       scale_off;
    logic [2:0]                 lvl;
    always_comb begin
      raw       = wetting_cfg_pkg::decode_level(upper_q[FLSB +: 3]);
      scale_off = i_sink_select[j] ? upper_q[wetting_cfg_pkg::SINK_AUTOSCALE_DISABLE_BIT]
                                   : upper_q[wetting_cfg_pkg::SOURCE_AUTOSCALE_DISABLE_BIT];
      lvl       = raw;
      if (i_continuous_mode && i_switch_closed[j] && !scale_off &&
          (raw == wetting_cfg_pkg::LEVEL_10MA || raw == wetting_cfg_pkg::LEVEL_15MA)) begin
        lvl = wetting_cfg_pkg::LEVEL_2MA;
      end
    end
    assign level_d[3*j +: 3] = lvl;
  end

  // ****************************************
  // Cleaning pulse timer
  // ****************************************
  wetting_cfg_pkg::pulse_state_type state_q;
  wetting_cfg_pkg::pulse_state_type state_d;
  logic [12:0] cyc_q;
  logic [12:0] cyc_d;
  logic [2:0]  units_q;
  logic [2:0]  units_d;
  logic [23:0] active_d;
  logic [23:0] plevel_d;

  always_comb begin
    state_d = state_q;
    cyc_d   = cyc_q;
    units_d = units_q;
    unique case (state_q)
      wetting_cfg_pkg::PULSE_IDLE: begin
        if (i_pulse_start) begin
          state_d = wetting_cfg_pkg::PULSE_RUN;
          cyc_d   = 13'h0000;
          units_d = pcfg_q[wetting_cfg_pkg::DURATION_LSB +: 3];
        end
      end
      wetting_cfg_pkg::PULSE_RUN: begin
        if (cyc_q == 13'(PULSE_UNIT_CYCLES - 1)) begin
          cyc_d = 13'h0000;
          if (units_q == 3'h0) begin
            state_d = wetting_cfg_pkg::PULSE_IDLE;
          end else begin
            units_d = units_q - 3'h1;
          end
        end else begin
          cyc_d = cyc_q + 13'h0001;
        end
      end
      default: state_d = wetting_cfg_pkg::PULSE_IDLE;
    endcase
    for (int k = 0; k < 24; k++) begin
      active_d[k] = (state_d == wetting_cfg_pkg::PULSE_RUN) && pen_q[k];
      plevel_d[k] = pcfg_q[k / wetting_cfg_pkg::GROUP_SIZE];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_q            <= wetting_cfg_pkg::PULSE_IDLE;
      cyc_q              <= 13'h0000;
      units_q            <= 3'h0;
      o_wetting_level    <= 36'h000000000;
      o_pulse_active     <= 24'h000000;
      o_pulse_level_15ma <= 24'h000000;
      o_pulse_busy       <= 1'b0;
    end else begin
      state_q            <= state_d;
      cyc_q              <= cyc_d;
      units_q            <= units_d;
      o_wetting_level    <= level_d;
      o_pulse_active     <= active_d;
      o_pulse_level_15ma <= plevel_d;
      o_pulse_busy       <= (state_d == wetting_cfg_pkg::PULSE_RUN);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] busy_len_q;
  logic [2:0]  dur_at_start_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      busy_len_q     <= 16'h0000;
      dur_at_start_q <= 3'h0;
    end else begin
      busy_len_q <= o_pulse_busy ? busy_len_q + 16'h0001 : 16'h0000;
      if (state_q == wetting_cfg_pkg::PULSE_IDLE && i_pulse_start) begin
        dur_at_start_q <= pcfg_q[wetting_cfg_pkg::DURATION_LSB +: 3];
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_level_decode;
    !i_continuous_mode |=> o_wetting_level[2:0] == wetting_cfg_pkg::decode_level($past(upper_q[2:0]));
  endproperty
  a_level_decode: assert property (p_level_decode) else $error("level code decode wrong");

  property p_sink_scale;
    i_continuous_mode && i_switch_closed[0] && i_sink_select[0] && !upper_q[22] && upper_q[2:0] > 3'h3
      |=> o_wetting_level[2:0] == wetting_cfg_pkg::LEVEL_2MA;
  endproperty
  a_sink_scale: assert property (p_sink_scale) else $error("sink auto-scale missing");

  property p_source_keep;
    i_continuous_mode && i_switch_closed[0] && !i_sink_select[0] && upper_q[21] && upper_q[2:0] == 3'h4
      |=> o_wetting_level[2:0] == wetting_cfg_pkg::LEVEL_10MA;
  endproperty
  a_source_keep: assert property (p_source_keep) else $error("source level not kept");

  property p_pulse_len;
    $fell(o_pulse_busy) |-> busy_len_q == 16'((dur_at_start_q + 1) * PULSE_UNIT_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("cleaning pulse length wrong");

  property p_group_level;
    ##1 o_pulse_level_15ma[18] == $past(pcfg_q[3]) && o_pulse_level_15ma[5] == $past(pcfg_q[0]);
  endproperty
  a_group_level: assert property (p_group_level) else $error("group pulse level wrong");

  property p_reset_upper;
    disable iff (1'b0) !i_reset_n |=> upper_q == 24'h000000;
  endproperty
  a_reset_upper: assert property (p_reset_upper) else $error("upper level reg not reset");

  property p_reset_pcfg;
    disable iff (1'b0) !i_reset_n |=> pcfg_q == 24'h000000 && !o_pulse_busy;
  endproperty
  a_reset_pcfg: assert property (p_reset_pcfg) else $error("pulse config not reset");

  property p_reset_pen;
    disable iff (1'b0) !i_reset_n |=> pen_q == 24'h000000 && o_pulse_active == 24'h000000;
  endproperty
  a_reset_pen: assert property (p_reset_pen) else $error("pulse enable not reset");

  property p_active;
    ##1 o_pulse_active == ({24{o_pulse_busy}} & $past(pen_q));
  endproperty
  a_active: assert property (p_active) else $error("pulse active mismatch");

  property p_reserved;
    i_reg_rd && (i_reg_addr == wetting_cfg_pkg::UPPER_LEVEL_OFFSET || i_reg_addr == wetting_cfg_pkg::PULSE_CONFIG_OFFSET)
      |=> !o_reg_rdata[23] &&
          ($past(i_reg_addr) != wetting_cfg_pkg::PULSE_CONFIG_OFFSET || o_reg_rdata[23:7] == 17'h00000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

endmodule // wetting_current_config_regs

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  localparam int UNIT = 4;
  logic        i_sys_clk         = 1'b0;
  logic        i_reset_n         = 1'b0;
  logic [5:0]  i_reg_addr        = 6'h00;
  logic        i_reg_wr          = 1'b0;
  logic [23:0] i_reg_wdata       = 24'h000000;
  logic        i_reg_rd          = 1'b0;
  logic [23:0] o_reg_rdata;
  logic        i_continuous_mode = 1'b0;
  logic [11:0] i_switch_closed   = 12'h000;
  logic [11:0] i_sink_select     = 12'h000;
  logic        i_pulse_start     = 1'b0;
  logic [35:0] o_wetting_level;
  logic [23:0] o_pulse_active;
  logic [23:0] o_pulse_level_15ma;
  logic        o_pulse_busy;
  int          err_count         = 0;
  int          checked           = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  wetting_current_config_regs #(.PULSE_UNIT_CYCLES(UNIT)) u_dut (
    .i_sys_clk          (i_sys_clk),
    .i_reset_n          (i_reset_n),
    .i_reg_addr         (i_reg_addr),
    .i_reg_wr           (i_reg_wr),
    .i_reg_wdata        (i_reg_wdata),
    .i_reg_rd           (i_reg_rd),
    .o_reg_rdata        (o_reg_rdata),
    .i_continuous_mode  (i_continuous_mode),
    .i_switch_closed    (i_switch_closed),
    .i_sink_select      (i_sink_select),
    .i_pulse_start      (i_pulse_start),
    .o_wetting_level    (o_wetting_level),
    .o_pulse_active     (o_pulse_active),
    .o_pulse_level_15ma (o_pulse_level_15ma),
    .o_pulse_busy       (o_pulse_busy)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge i_sys_clk);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    @(negedge i_sys_clk);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    @(negedge i_sys_clk);
    check({12'h000, o_reg_rdata}, {12'h000, e});
  endtask

  // Expected level of each covered input from a register word
  function automatic logic [35:0] exp_lvl(input logic [23:0] r);
    logic [35:0] v;
    int          f;
    logic [2:0]  c;
    v = '0;
    for (int j = 0; j < 12; j++) begin
      f = (j < 10) ? j / 2 : j - 5;
      c = r[3*f +: 3];
      if (c > 3'h4) c = 3'h5;
      if (i_continuous_mode && i_switch_closed[j] && c >= 3'h4 && !r[i_sink_select[j] ? 22 : 21]) c = 3'h2;
      v[3*j +: 3] = c;
    end
    return v;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(6'h1e, 24'h000000);
    rd(6'h1f, 24'h000000);
    rd(6'h20, 24'h000000);
    check(o_wetting_level, '0);
    check({11'h000, o_pulse_busy, o_pulse_active}, '0);
  endtask

  task automatic t_reserved();
    wr(6'h1e, 24'hffffff);
    rd(6'h1e, 24'h7fffff);
    wr(6'h1f, 24'hffffff);
    rd(6'h1f, 24'h00007f);
    wr(6'h20, 24'hffffff);
    rd(6'h20, 24'hffffff);
    wr(6'h21, 24'h123456);
    rd(6'h21, 24'h000000);
    rd(6'h1e, 24'h7fffff);
    wr(6'h1f, 24'h000000);
    wr(6'h20, 24'h000000);
  endtask

  task automatic t_decode();
    logic [23:0] d;
    for (int k = 0; k < 8; k++) begin
      d = '0;
      for (int i = 0; i < 7; i++) d[3*i +: 3] = 3'((k + i) % 8);
      wr(6'h1e, d);
      @(negedge i_sys_clk);
      check(o_wetting_level, exp_lvl(d));
    end
  endtask

  task automatic t_autoscale();
    logic [23:0] d;
    i_continuous_mode = 1'b1;
    i_switch_closed   = 12'hf7f;
    for (int m = 0; m < 16; m++) begin
      i_sink_select = (m < 8) ? 12'h0f1 : 12'hf0e;
      d = {1'b0, 2'(m % 4), 21'h000000};
      for (int i = 0; i < 7; i++) d[3*i +: 3] = (m % 8 < 4) ? 3'h4 : 3'h7;
      wr(6'h1e, d);
      @(negedge i_sys_clk);
      check(o_wetting_level, exp_lvl(d));
    end
    i_continuous_mode = 1'b0;
    @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    check(o_wetting_level, exp_lvl(d));
  endtask

  task automatic t_pulse();
    int n;
    wr(6'h20, 24'ha5a5a5);
    wr(6'h1f, 24'h000025);
    @(negedge i_sys_clk);
    check({12'h000, o_pulse_level_15ma}, 36'h00003f03f);
    check({12'h000, o_pulse_active}, '0);
    i_pulse_start = 1'b1;
    n = 0;
    for (int i = 0; i < 100; i++) begin
      @(negedge i_sys_clk);
      i_pulse_start = 1'b0;
      if (o_pulse_busy === 1'b1) begin
        n++;
        if (n == 2) i_pulse_start = 1'b1;
        if (n == 1) check({12'h000, o_pulse_active}, 36'h000a5a5a5);
      end
    end
    check(36'(n), 36'(3 * UNIT));
    check({12'h000, o_pulse_active}, '0);
  endtask

  task automatic print_verdict();
    $display("Counts: %0d mismatches in %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    t_reset();
    t_reserved();
    t_decode();
    t_autoscale();
    t_pulse();
    print_verdict();
  end
endmodule // testbench
